// ===== hdl/srs_sequencer.sv
`timescale 1ns/10ps
// How it works
// R1: core is held halted for the whole reset state.
// R2: module registers reset to defaults; power-on-only bits kept otherwise.
// R3: interrupts and timers are held disabled during reset.
// R4: RAM contents are never written by reset except identifier area.
// R5: port latches forced to one, drivers forced open-drain.
// R6: weak pull-ups enabled during and after reset.
// R7: supply-monitor reset drives reset pin low while reset lasts.
// R8: on exit, system clock selects low-power oscillator.
// R9: on exit, watchdog enabled without firmware action.
// R10: on exit, program counter cleared, fetch from address zero.
// R11: after each reset, 128-bit identifier written to top 16 XRAM bytes.
// R12: firmware may overwrite identifier area until next reset.
// R13: stop mode left only through a reset, running normal sequence.
// R14: all reset sources merged into one request, held while any active.
module srs_sequencer
    import srs_pkg::*;
#(
    parameter int HOLD_CYCLES = srs_pkg::SRS_HOLD_CYCLES,
    parameter logic [127:0] ID_VALUE = 128'h0123456789abcdeffedcba9876543210
) (
    // clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // reset sources (pin source is asynchronous)
    input  wire logic                          por_req,
    input  wire logic                          vmon_req,
    input  wire logic                          rst_pin_n_in,
    input  wire logic                          wdt_req,
    // stop mode request from core
    input  wire logic                          stop_req,
    // reset pin drive
    output logic                               rst_pin_out,
    output logic                               rst_pin_oe,
    // core control
    output logic                               core_halt,
    output logic                               core_pc_load,
    output logic [srs_pkg::SRS_PC_W-1:0]       core_pc,
    output logic                               module_reset,
    output logic                               por_only_reset,
    output logic                               irq_disable,
    output logic                               timer_disable,
    output logic                               wdt_enable,
    output logic [srs_pkg::SRS_CLKSEL_W-1:0]   clk_sel,
    output logic                               clk_sel_force,
    // port control
    output logic [srs_pkg::SRS_PORT_W-1:0]     port_latch,
    output logic                               port_force,
    output logic                               port_open_drain,
    output logic                               weak_pullup_en,
    // identifier write port into xram
    output logic                               xram_we,
    output logic [srs_pkg::SRS_XADDR_W-1:0]    xram_addr,
    output logic [7:0]                         xram_wdata,
    // status
    output logic [srs_pkg::SRS_SRC_W-1:0]      reset_cause
);
    import srs_pkg::*;

    localparam int CNT_W = $clog2(HOLD_CYCLES + 1);
    localparam logic [SRS_XADDR_W-1:0] ID_BASE =
        SRS_XADDR_W'((1 << SRS_XADDR_W) - SRS_ID_BYTES);

    // -----------------------------------------------------------------
    // state record
    // -----------------------------------------------------------------
    typedef struct packed {
        srs_state_type              st;
        logic [CNT_W-1:0]           hold;
        logic [3:0]                 idx;
        logic [SRS_SRC_W-1:0]       cause;
        logic                       halt;
        logic                       irq_off;
        logic                       pc_load;
        logic                       mod_rst;
        logic                       por_rst;
        logic                       pin_drv;
        logic                       we;
        logic [SRS_XADDR_W-1:0]     addr;
        logic [7:0]                 wdata;
        logic                       wdt_en;
        logic                       clk_force;
    } srs_seq_type;

    srs_seq_type r_q;
    srs_seq_type r_d;
    logic        pin_n_sync;
    logic [SRS_SRC_W-1:0] src;
    logic        any_req;

    // all checks below run on the system clock and rest during reset
    default clocking chk_cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // -----------------------------------------------------------------
    // source merge
    // -----------------------------------------------------------------
    srs_sync u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     (~rst_pin_n_in),
        .dout    (pin_n_sync)
    );

    // the pin sync output is high while the pin is pulled low; our own
    // drive of the pin is masked so it cannot hold the reset for ever
    // limitation: a looped-back pin still reads low a few cycles after
    always_comb begin
        src               = '0;
        src[SRS_SRC_POR]  = por_req;
        src[SRS_SRC_VMON] = vmon_req;
        src[SRS_SRC_PIN]  = pin_n_sync && !r_q.pin_drv;
        src[SRS_SRC_WDT]  = wdt_req;
        any_req           = |src; // R14
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    always_comb begin
        r_d         = r_q;
        r_d.pc_load = 1'b0;
        r_d.we      = 1'b0;
        if (any_req) begin
            // any source restarts the reset state, even from stop mode
            r_d.st      = SRS_ST_RESET; // R14 R13
            r_d.hold    = '0;
            r_d.cause   = src;
            r_d.halt    = 1'b1; // R1
            r_d.irq_off = 1'b1; // R3
            r_d.mod_rst = 1'b1; // R2
            // the power-on marking stands until the reset state ends, the pin drive until the exit
            r_d.por_rst = r_q.por_rst | src[SRS_SRC_POR]; // R2
            r_d.pin_drv = r_q.pin_drv | src[SRS_SRC_VMON]; // R7
            r_d.wdt_en  = 1'b0;
            r_d.clk_force = 1'b1;
        end else begin
            case (r_q.st)
                SRS_ST_RESET: begin
                    // a monitor reset keeps the pin driven until the exit
                    if (r_q.hold == CNT_W'(HOLD_CYCLES)) begin
                        r_d.st      = SRS_ST_IDLOAD;
                        r_d.idx     = '0;
                        r_d.mod_rst = 1'b0;
                        r_d.por_rst = 1'b0;
                    end else begin
                        r_d.hold = r_q.hold + CNT_W'(1);
                    end
                end
                SRS_ST_IDLOAD: begin
                    // identifier bytes, least significant at lowest addr
                    r_d.we    = 1'b1; // R11
                    r_d.addr  = ID_BASE + SRS_XADDR_W'(r_q.idx);
                    r_d.wdata = ID_VALUE[r_q.idx*8 +: 8];
                    r_d.idx   = r_q.idx + 4'h1;
                    if (r_q.idx == 4'(SRS_ID_BYTES - 1)) begin
                        // exit: core released with its defaults, pin let go
                        r_d.st        = SRS_ST_RUN;
                        r_d.halt      = 1'b0; // R1
                        r_d.irq_off   = 1'b0; // R3
                        r_d.pin_drv   = 1'b0; // R7
                        r_d.pc_load   = 1'b1; // R10
                        r_d.wdt_en    = 1'b1; // R9
                        r_d.clk_force = 1'b0; // R8
                    end
                end
                SRS_ST_RUN: begin
                    // no identifier writes here; firmware owns the area
                    if (stop_req) begin // R12
                        r_d.st   = SRS_ST_STOP;
                        r_d.halt = 1'b1;
                    end
                end
                SRS_ST_STOP: begin
                    r_d.halt = 1'b1; // R13
                end
                default: begin
                    r_d.st = SRS_ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            r_q           <= '0;
            r_q.st        <= SRS_ST_RESET;
            r_q.halt      <= 1'b1;
            r_q.irq_off   <= 1'b1;
            r_q.mod_rst   <= 1'b1;
            r_q.por_rst   <= 1'b1;
            r_q.clk_force <= 1'b1;
            r_q.cause     <= SRS_SRC_W'(1);
        end else begin
            r_q <= r_d;
        end
    end

    // -----------------------------------------------------------------
    // outputs, from the state record or fixed values
    // -----------------------------------------------------------------
    assign core_halt      = r_q.halt;
    assign core_pc_load   = r_q.pc_load;
    assign core_pc        = SRS_RESET_VECTOR; // R10
    assign module_reset   = r_q.mod_rst;
    assign por_only_reset = r_q.por_rst;
    assign irq_disable    = r_q.irq_off; // R3
    assign timer_disable  = r_q.mod_rst; // R3
    assign wdt_enable     = r_q.wdt_en;
    assign clk_sel        = SRS_CLK_LPOSC; // R8
    assign clk_sel_force  = r_q.clk_force; // R8
    assign port_latch     = SRS_LATCH_RESET; // R5
    assign port_force     = r_q.mod_rst; // R5
    assign port_open_drain = r_q.mod_rst; // R5
    assign weak_pullup_en = 1'b1; // R6
    assign rst_pin_out    = 1'b0;
    assign rst_pin_oe     = r_q.pin_drv; // R7
    assign xram_we        = r_q.we; // R4
    assign xram_addr      = r_q.addr;
    assign xram_wdata     = r_q.wdata;
    assign reset_cause    = r_q.cause;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    // core stops as soon as any source is seen
    a_halt_in_reset: assert property (any_req |=> core_halt) // R1
        else $error("core not halted");
    // module registers are held at their defaults
    a_mod_reset_on: assert property (any_req |=> module_reset) // R2
        else $error("no module reset");
    // power-on marking stands until the module reset ends
    a_por_kept: assert property ( // R2
        por_only_reset && module_reset |=> por_only_reset || !module_reset)
        else $error("power-on marking lost");
    // interrupts and timers stay off while modules are reset
    a_irq_held_off: assert property ( // R3
        module_reset |-> irq_disable && timer_disable)
        else $error("irq or timer live in reset");

    // only the identifier area is ever written by the sequencer
    a_xram_only_id: assert property (xram_we |-> xram_addr >= ID_BASE) // R4
        else $error("ram touched");
    // port latches at one, drivers open-drain
    a_port_forced: assert property ( // R5
        module_reset |-> port_force && port_open_drain
        && port_latch == SRS_LATCH_RESET) else $error("ports not forced");
    // pull-ups are never switched off
    a_pullup_on: assert property (weak_pullup_en) // R6
        else $error("pullups off");

    // monitor reset drives the pin low at once
    a_vmon_pin: assert property ( // R7
        vmon_req |=> rst_pin_oe && !rst_pin_out)
        else $error("pin not driven");
    // pin drive stands until the core is released
    a_pin_to_exit: assert property ( // R7
        rst_pin_oe |=> rst_pin_oe || $fell(core_halt))
        else $error("pin drive ended early");
    // pin drive is gone once the core runs
    a_pin_ends: assert property ($fell(core_halt) |-> !rst_pin_oe) // R7
        else $error("pin drive outlasts reset");

    // exit: clock source free, watchdog on, fetch from zero
    a_exit_state: assert property ( // R8 R9 R10
        $fell(core_halt) |-> core_pc_load && wdt_enable && !clk_sel_force
        && core_pc == SRS_RESET_VECTOR) else $error("bad exit");
    // low-power oscillator forced for the whole module reset
    a_clk_forced: assert property ( // R8
        module_reset |-> clk_sel_force && clk_sel == SRS_CLK_LPOSC)
        else $error("clock not forced");
    // watchdog only comes on at the exit
    a_wdt_off: assert property (module_reset |-> !wdt_enable) // R9
        else $error("watchdog on in reset");
    // restart strobe lasts one cycle
    a_pc_pulse: assert property (core_pc_load |=> !core_pc_load) // R10
        else $error("pc load stuck");

    // identifier load follows the module reset
    a_id_load: assert property ($fell(module_reset) |=> xram_we [*8]) // R11
        else $error("id not loaded");
    // first identifier byte lands at the base of the area
    a_id_first_byte: assert property ( // R11
        $fell(module_reset) |=> xram_addr == ID_BASE
        && xram_wdata == ID_VALUE[7:0]) else $error("id byte misplaced");
    // no identifier writes once firmware owns the area
    a_run_no_id: assert property ( // R12
        r_q.st == SRS_ST_RUN && !core_pc_load |-> !xram_we)
        else $error("id area rewritten in run");
    // stop mode is left only through a reset
    a_stop_hold: assert property ( // R13
        r_q.st == SRS_ST_STOP && !any_req |=> core_halt)
        else $error("stop left");
    // a standing request keeps the reset state
    a_merge_hold: assert property ( // R14
        any_req [*2] |-> r_q.st == SRS_ST_RESET)
        else $error("reset not held");

    // main scenarios
    c_vmon_reset: cover property (vmon_req);
    c_two_sources: cover property (vmon_req && wdt_req);
    c_pin_reset: cover property ($rose(pin_n_sync));
    c_exit_run: cover property ($fell(core_halt));
    c_stop_wake: cover property (r_q.st == SRS_ST_STOP ##1 any_req);
endmodule

// ===== hdl/srs_pkg.sv
package srs_pkg;
    // widths and reset values of the controls that the sequencer forces
    localparam int          SRS_SRC_W        = 4;     // number of reset sources
    localparam int          SRS_SRC_POR      = 0;     // power-on source bit
    localparam int          SRS_SRC_VMON     = 1;     // supply monitor bit
    localparam int          SRS_SRC_PIN      = 2;     // external pin bit
    localparam int          SRS_SRC_WDT      = 3;     // watchdog bit
    localparam int          SRS_PC_W         = 16;
    localparam logic [15:0] SRS_RESET_VECTOR = 16'h0000;
    localparam int          SRS_CLKSEL_W     = 2;
    localparam logic [1:0]  SRS_CLK_LPOSC    = 2'h0;  // low-power oscillator
    localparam int          SRS_ID_BITS      = 128;
    localparam int          SRS_ID_BYTES     = 16;
    localparam int          SRS_XADDR_W      = 13;    // 8 kB of XRAM
    localparam logic [7:0]  SRS_LATCH_RESET  = 8'hff; // port latches at one
    localparam int          SRS_PORT_W       = 8;
    localparam int          SRS_HOLD_CYCLES  = 4;     // reset stretch length

    // sequencer states
    typedef enum logic [1:0] {
        SRS_ST_RESET,
        SRS_ST_IDLOAD,
        SRS_ST_RUN,
        SRS_ST_STOP
    } srs_state_type;
endpackage

// ===== hdl/srs_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser; output changes once stages two and three agree
module srs_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // data
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic [2:0] stg;
        logic       out;
    } srs_sync_type;

    srs_sync_type s_q;
    srs_sync_type s_d;

    // shift chain and agreement filter
    always_comb begin
        s_d       = s_q;
        s_d.stg   = {s_q.stg[1:0], din};
        if (s_q.stg[1] == s_q.stg[2]) begin
            s_d.out = s_q.stg[2];
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.out;
endmodule

// ===== testbench/srs_xram_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// xram beside the sequencer
// ----------------------------------------------------------------------
// holds identifier writes from the sequencer and firmware writes
module srs_xram_model (
    // clock
    input wire logic        sys_clk,
    // sequencer write port
    input wire logic        xram_we,
    input wire logic [12:0] xram_addr,
    input wire logic [7:0]  xram_wdata,
    // firmware write port
    input wire logic        fw_we,
    input wire logic [12:0] fw_addr,
    input wire logic [7:0]  fw_wdata
);
    logic [7:0] mem [0:8191];

    // one write per port per edge; firmware lands last on a clash
    always @(posedge sys_clk) begin
        if (xram_we)
            mem[xram_addr] <= xram_wdata;
        if (fw_we)
            mem[fw_addr] <= fw_wdata;
    end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// sequencer bench
// ----------------------------------------------------------------------
module tb;
    import srs_pkg::*;
    typedef struct packed {logic oe; logic [3:0] src;} srs_row_type;
    localparam logic [127:0] ID = 128'h5a5a1234c3c3beef0f0f7777a1b2c3d4;
    logic        sys_clk = 1'b0;
    logic        rst, por_req, vmon_req, rst_pin_n_in, wdt_req, stop_req;
    logic        rst_pin_out, rst_pin_oe, core_halt, core_pc_load;
    logic [15:0] core_pc;
    logic        module_reset, por_only_reset, irq_disable, timer_disable;
    logic        wdt_enable, clk_sel_force, port_force, port_open_drain;
    logic        weak_pullup_en, xram_we, fw_we;
    logic [1:0]  clk_sel;
    logic [7:0]  port_latch, xram_wdata, fw_wdata;
    logic [12:0] xram_addr, fw_addr;
    logic [3:0]  reset_cause;
    int          n_errors = 0;
    int          num_checks = 0;
    // rows: {oe, wdt, pin, vmon, por}
    srs_row_type rows [5] = '{5'h01, 5'h12, 5'h04, 5'h08, 5'h1a};

    always #12.5 sys_clk = ~sys_clk;

    srs_sequencer #(.HOLD_CYCLES(4), .ID_VALUE(ID)) dut_u (.*);
    srs_xram_model mem_u (.sys_clk(sys_clk), .xram_we(xram_we),
        .xram_addr(xram_addr), .xram_wdata(xram_wdata), .fw_we(fw_we),
        .fw_addr(fw_addr), .fw_wdata(fw_wdata));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic fw(input logic [12:0] a, input logic [7:0] d);
        fw_addr = a;
        fw_wdata = d;
        fw_we = 1'b1;
        cyc(1);
        fw_we = 1'b0;
    endtask

    // outputs that must hold while the reset state lasts
    task automatic in_rst;
        chk(core_halt, 1);
        chk(module_reset, 1);
        chk(irq_disable, 1);
        chk(timer_disable, 1);
        chk(port_latch, 8'hff);
        chk(port_force, 1);
        chk(port_open_drain, 1);
        chk(weak_pullup_en, 1);
    endtask

    // wait for the exit pulse, then check restart state and identifier
    task automatic wait_exit;
        for (int i = 0; i < 200 && core_pc_load !== 1'b1; i++)
            cyc(1);
        chk(core_pc_load, 1);
        chk(core_pc, 16'h0000);
        chk(core_halt, 0);
        chk(wdt_enable, 1);
        chk(clk_sel, 2'h0);
        chk(clk_sel_force, 0);
        chk(rst_pin_oe, 0);
        chk(weak_pullup_en, 1);
        cyc(1);
        for (int i = 0; i < 16; i++)
            chk(mem_u.mem[13'h1ff0 + 13'(i)], ID[8*i +: 8]);
    endtask

    task results;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {por_req, vmon_req, wdt_req, stop_req, fw_we} = 5'h00;
        rst_pin_n_in = 1'b1;
        fw_addr = 13'h0000;
        fw_wdata = 8'h00;
        cyc(10);
        in_rst;
        chk(wdt_enable, 0);
        rst = 1'b0;
        wait_exit;
        $display("test reset done");
        // one reset per source row; ram below the id area must survive
        for (int r = 0; r < 5; r++) begin
            fw(13'h0100, 8'(r + 16));
            {wdt_req, vmon_req, por_req} = {rows[r].src[3], rows[r].src[1:0]};
            rst_pin_n_in = ~rows[r].src[2];
            cyc(8);
            in_rst;
            chk(rst_pin_oe, rows[r].oe);
            chk(reset_cause, rows[r].src);
            chk(por_only_reset, rows[r].src[0]);
            {por_req, vmon_req, wdt_req} = 3'h0;
            rst_pin_n_in = 1'b1;
            wait_exit;
            chk(mem_u.mem[13'h0100], 8'(r + 16));
            $display("test source row %0d done", r);
        end
        // pin drive outlasts the monitor request, until the exit
        vmon_req = 1'b1;
        cyc(4);
        vmon_req = 1'b0;
        cyc(2);
        chk(rst_pin_oe, 1);
        chk(core_halt, 1);
        wait_exit;
        $display("test monitor drop done");
        // firmware overwrite persists until the next reset reloads
        fw(13'h1ff5, 8'ha5);
        cyc(10);
        chk(mem_u.mem[13'h1ff5], 8'ha5);
        wdt_req = 1'b1;
        cyc(1);
        wdt_req = 1'b0;
        wait_exit;
        $display("test overwrite done");
        // stop mode is left only through a reset
        stop_req = 1'b1;
        cyc(1);
        stop_req = 1'b0;
        cyc(30);
        chk(core_halt, 1);
        chk(core_pc_load, 0);
        wdt_req = 1'b1;
        cyc(1);
        wdt_req = 1'b0;
        wait_exit;
        $display("test stop done");
        results;
    end

    // watchdog against a hung sequence
    initial begin
        #(25 * 6000);
        n_errors++;
        results;
    end
endmodule
